// *** hdl/eeb_pkg.sv ***
package eeb_pkg;
  localparam int EEB_WORD_BITS = 8;
  localparam int EEB_RECOVER_CLOCKS = 9;
  localparam logic [3:0] EEB_DEV_PREFIX = 4'hA;
  localparam logic [2:0] EEB_DEV_ADDR_DEF = 3'h0;
  localparam int EEB_CLK_MHZ = 50;
  localparam int EEB_TBUF_NS = 4700;
  localparam int EEB_TBUF_CYC = (EEB_TBUF_NS * EEB_CLK_MHZ + 999) / 1000;
  localparam int EEB_TWR_US = 5000;
  localparam int EEB_TWR_CYC = EEB_TWR_US * EEB_CLK_MHZ;
  localparam int EEB_HALF_SCL_CYC = 125;
  localparam logic [7:0] EEB_IDLE_BYTE = 8'hFF;
endpackage

// *** hdl/eeb_if.sv ***
`timescale 1ns/1ps
interface eeb_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic scl;
  logic sda;
  modport device (
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe_n
  );
  modport master (
    input scl,
    input sda,
    output scl_o,
    output scl_oe_n,
    output sda_m_o,
    output sda_m_oe_n
  );
endinterface

// *** hdl/eeb_device.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1: sda changes only while scl low
// R2: sda change with scl high is control
// R3: sda fall, scl high is start
// R4: sda rise, scl high is stop
// R5: stop after read enters standby
// R6: words are 8 bits, msb first
// R7: device acknowledges on ninth clock
// R8: standby at reset and after stop; a stop after a write goes busy first, standby when the write ends
// R9: master recovers bus with nine clocks; code stops at nine scl falls, the first from idle high, or once sda reads high
// R10: master waits bus free time after stop
// R11: first word lsb selects read or write
// R12: ack address only on match
// R13: ignore bus during internal write
// R14: release sda for one, never drive high
module eeb_device
  import eeb_pkg::*;
#(
  parameter int TWR_CYC = EEB_TWR_CYC,
  parameter logic [2:0] DEV_ADDR = EEB_DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  eeb_if.device bus,
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic standby,
  output logic busy
);
  typedef enum logic [2:0] {
    EEB_ST_IDLE, EEB_ST_ADDR, EEB_ST_RX, EEB_ST_TX, EEB_ST_ACK, EEB_ST_MACK, EEB_ST_WRITE
  } eeb_dst_t;

  // three-stage samplers; stage one feeds only stage two
  logic [2:0] scl_sync_reg, scl_sync_next, sda_sync_reg, sda_sync_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  eeb_dst_t st_reg, st_next, after_ack_reg, after_ack_next;
  logic [7:0] sh_reg, sh_next, rx_data_reg, rx_data_next;
  logic [3:0] bit_reg, bit_next;
  logic read_reg, read_next, wrote_reg, wrote_next, drive_low_reg, drive_low_next;
  logic rx_valid_reg, rx_valid_next, tx_take_reg, tx_take_next;
  logic [31:0] wr_cnt_reg, wr_cnt_next;

  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], bus.scl};
    sda_sync_next = {sda_sync_reg[1:0], bus.sda};
    scl_next = (scl_sync_reg[2] == scl_sync_reg[1]) ? scl_sync_reg[2] : scl_reg;
    sda_next = (sda_sync_reg[2] == sda_sync_reg[1]) ? sda_sync_reg[2] : sda_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  assign scl_rise = scl_next & ~scl_reg;
  assign scl_fall = ~scl_next & scl_reg;
  // data edges under a steady high clock are control events, not bits
  assign start_ev = scl_reg & scl_next & sda_reg & ~sda_next; // [R2] [R3]
  assign stop_ev = scl_reg & scl_next & ~sda_reg & sda_next; // [R2] [R4]

  always_comb begin
    st_next = st_reg;
    after_ack_next = after_ack_reg;
    sh_next = sh_reg;
    rx_data_next = rx_data_reg;
    bit_next = bit_reg;
    read_next = read_reg;
    wrote_next = wrote_reg;
    drive_low_next = drive_low_reg;
    rx_valid_next = 1'h0;
    tx_take_next = 1'h0;
    wr_cnt_next = wr_cnt_reg;
    if (st_reg == EEB_ST_WRITE) begin
      // inputs ignored until the self-timed write ends
      drive_low_next = 1'h0; // [R13]
      if (wr_cnt_reg == 32'h0) begin
        st_next = EEB_ST_IDLE; // [R8]
      end else begin
        wr_cnt_next = wr_cnt_reg - 32'h1;
      end
    end else if (stop_ev) begin
      drive_low_next = 1'h0;
      // a read after a dummy write commits nothing
      if (wrote_reg && !read_reg) begin
        st_next = EEB_ST_WRITE;
        wr_cnt_next = 32'(TWR_CYC);
      end else begin
        st_next = EEB_ST_IDLE; // [R5] [R8]
      end
      wrote_next = 1'h0;
    end else if (start_ev) begin
      st_next = EEB_ST_ADDR;
      bit_next = 4'h0;
      drive_low_next = 1'h0;
    end else begin
      case (st_reg)
        EEB_ST_IDLE: begin
        end
        EEB_ST_ADDR, EEB_ST_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_reg}; // [R1] [R6]
            bit_next = bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'(EEB_WORD_BITS)) begin
            bit_next = 4'h0;
            if (st_reg == EEB_ST_ADDR) begin
              read_next = sh_reg[0]; // [R11]
              if (sh_reg[7:1] == {EEB_DEV_PREFIX, DEV_ADDR}) begin
                drive_low_next = 1'h1; // [R12]
                st_next = EEB_ST_ACK;
                after_ack_next = sh_reg[0] ? EEB_ST_TX : EEB_ST_RX;
              end else begin
                st_next = EEB_ST_IDLE; // [R12]
              end
            end else begin
              rx_data_next = sh_reg;
              rx_valid_next = 1'h1;
              wrote_next = 1'h1;
              drive_low_next = 1'h1; // [R7]
              st_next = EEB_ST_ACK;
              after_ack_next = EEB_ST_RX;
            end
          end
        end
        EEB_ST_ACK: begin
          if (scl_fall) begin
            st_next = after_ack_reg;
            bit_next = 4'h0;
            if (after_ack_reg == EEB_ST_TX) begin
              sh_next = {tx_data[6:0], 1'h0};
              drive_low_next = ~tx_data[7]; // [R6] [R14]
              tx_take_next = 1'h1;
            end else begin
              drive_low_next = 1'h0;
            end
          end
        end
        EEB_ST_TX: begin
          if (scl_rise) begin
            bit_next = bit_reg + 4'h1;
          end
          if (scl_fall) begin
            if (bit_reg == 4'(EEB_WORD_BITS)) begin
              drive_low_next = 1'h0;
              st_next = EEB_ST_MACK;
            end else begin
              drive_low_next = ~sh_reg[7]; // [R1] [R14]
              sh_next = {sh_reg[6:0], 1'h0};
            end
          end
        end
        EEB_ST_MACK: begin
          if (scl_rise) begin
            // master ack continues the read; no ack goes straight to idle
            st_next = sda_reg ? EEB_ST_IDLE : EEB_ST_ACK;
            after_ack_next = EEB_ST_TX;
          end
        end
        default: st_next = EEB_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= EEB_ST_IDLE;
      after_ack_reg <= EEB_ST_IDLE;
      sh_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      bit_reg <= 4'h0;
      read_reg <= 1'h0;
      wrote_reg <= 1'h0;
      drive_low_reg <= 1'h0;
      rx_valid_reg <= 1'h0;
      tx_take_reg <= 1'h0;
      wr_cnt_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      after_ack_reg <= after_ack_next;
      sh_reg <= sh_next;
      rx_data_reg <= rx_data_next;
      bit_reg <= bit_next;
      read_reg <= read_next;
      wrote_reg <= wrote_next;
      drive_low_reg <= drive_low_next;
      rx_valid_reg <= rx_valid_next;
      tx_take_reg <= tx_take_next;
      wr_cnt_reg <= wr_cnt_next;
    end
  end

  // open drain: only ever pull low
  assign bus.sda_d_o = 1'h0; // [R14]
  assign bus.sda_d_oe_n = ~drive_low_reg; // [R14]
  assign rx_data = rx_data_reg;
  assign rx_valid = rx_valid_reg;
  assign tx_take = tx_take_reg;
  assign standby = (st_reg == EEB_ST_IDLE);
  assign busy = (st_reg == EEB_ST_WRITE);
endmodule

// *** hdl/eeb_master.sv ***
`timescale 1ns/1ps
module eeb_master
  import eeb_pkg::*;
#(
  parameter int HALF_CYC = EEB_HALF_SCL_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  eeb_if.master bus,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_last,
  input wire logic cmd_recover,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic rsp_valid
);
  typedef enum logic [2:0] {
    EEB_MS_IDLE, EEB_MS_START, EEB_MS_BITS, EEB_MS_STOP, EEB_MS_FREE, EEB_MS_RECOV
  } eeb_mst_t;

  logic [2:0] sda_sync_reg, sda_sync_next;
  logic sda_reg, sda_next;
  eeb_mst_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next, rsp_data_reg, rsp_data_next;
  logic [3:0] bit_reg, bit_next;
  logic [2:0] ph_reg, ph_next;
  logic [15:0] cnt_reg, cnt_next;
  logic scl_reg, scl_next, sdo_reg, sdo_next;
  logic rd_reg, rd_next, last_reg, last_next, stop_reg, stop_next;
  logic ack_reg, ack_next, rv_reg, rv_next;
  logic tick;

  assign tick = (cnt_reg == 16'h0);

  always_comb begin
    sda_sync_next = {sda_sync_reg[1:0], bus.sda};
    sda_next = (sda_sync_reg[2] == sda_sync_reg[1]) ? sda_sync_reg[2] : sda_reg;
    st_next = st_reg;
    sh_next = sh_reg;
    rsp_data_next = rsp_data_reg;
    bit_next = bit_reg;
    ph_next = ph_reg;
    cnt_next = tick ? 16'(HALF_CYC - 1) : cnt_reg - 16'h1;
    scl_next = scl_reg;
    sdo_next = sdo_reg;
    rd_next = rd_reg;
    last_next = last_reg;
    stop_next = stop_reg;
    ack_next = ack_reg;
    rv_next = 1'h0;
    case (st_reg)
      EEB_MS_IDLE: begin
        if (cmd_valid) begin
          sh_next = cmd_byte;
          rd_next = cmd_read;
          last_next = cmd_last;
          stop_next = cmd_stop;
          bit_next = 4'h0;
          ph_next = 3'h0;
          cnt_next = 16'(HALF_CYC - 1);
          st_next = cmd_recover ? EEB_MS_RECOV : (cmd_start ? EEB_MS_START : EEB_MS_BITS);
        end
      end
      EEB_MS_START: if (tick) begin
        ph_next = ph_reg + 3'h1;
        case (ph_reg)
          3'h0: begin
            sdo_next = 1'h1;
          end
          3'h1: scl_next = 1'h1;
          3'h2: sdo_next = 1'h0; // [R3]
          default: begin
            scl_next = 1'h0;
            ph_next = 3'h0;
            st_next = EEB_MS_BITS;
          end
        endcase
      end
      EEB_MS_BITS: if (tick) begin
        if (!scl_reg) begin
          if (ph_reg == 3'h0) begin
            // data moves only with scl low
            sdo_next = (bit_reg == 4'(EEB_WORD_BITS)) ? (rd_reg ? last_reg : 1'h1)
                     : (rd_reg ? 1'h1 : sh_reg[7]); // [R1] [R6]
            ph_next = 3'h1;
          end else begin
            scl_next = 1'h1;
            ph_next = 3'h0;
          end
        end else begin
          scl_next = 1'h0;
          if (bit_reg == 4'(EEB_WORD_BITS)) begin
            ack_next = ~sda_reg; // [R7]
            rsp_data_next = sh_reg;
            rv_next = 1'h1;
            st_next = stop_reg ? EEB_MS_STOP : EEB_MS_IDLE;
          end else begin
            sh_next = {sh_reg[6:0], sda_reg}; // [R6]
            bit_next = bit_reg + 4'h1;
          end
        end
      end
      EEB_MS_STOP: if (tick) begin
        ph_next = ph_reg + 3'h1;
        case (ph_reg)
          3'h0: sdo_next = 1'h0;
          3'h1: scl_next = 1'h1;
          default: begin
            sdo_next = 1'h1; // [R4]
            cnt_next = 16'(EEB_TBUF_CYC);
            st_next = EEB_MS_FREE;
          end
        endcase
      end
      EEB_MS_FREE: if (tick) st_next = EEB_MS_IDLE; // [R10]
      EEB_MS_RECOV: if (tick) begin
        sdo_next = 1'h1;
        if (scl_reg) begin
          scl_next = 1'h0;
          bit_next = bit_reg + 4'h1;
        end else if (sda_reg && bit_reg != 4'h0) begin
          // sda seen high: start, then stop if cmd_recover is still held, else send the byte
          ph_next = 3'h0;
          stop_next = 1'h1;
          st_next = EEB_MS_START; // [R9]
        end else if (bit_reg == 4'(EEB_RECOVER_CLOCKS)) begin
          st_next = EEB_MS_IDLE;
        end else begin
          scl_next = 1'h1; // [R9]
        end
      end
      default: st_next = EEB_MS_IDLE;
    endcase
    if (st_reg == EEB_MS_START && st_next == EEB_MS_BITS && stop_reg && cmd_recover) begin
      st_next = EEB_MS_STOP;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_sync_reg <= 3'h7;
      sda_reg <= 1'h1;
      st_reg <= EEB_MS_IDLE;
      sh_reg <= 8'h00;
      rsp_data_reg <= 8'h00;
      bit_reg <= 4'h0;
      ph_reg <= 3'h0;
      cnt_reg <= 16'h0;
      scl_reg <= 1'h1;
      sdo_reg <= 1'h1;
      rd_reg <= 1'h0;
      last_reg <= 1'h0;
      stop_reg <= 1'h0;
      ack_reg <= 1'h0;
      rv_reg <= 1'h0;
    end else begin
      sda_sync_reg <= sda_sync_next;
      sda_reg <= sda_next;
      st_reg <= st_next;
      sh_reg <= sh_next;
      rsp_data_reg <= rsp_data_next;
      bit_reg <= bit_next;
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      scl_reg <= scl_next;
      sdo_reg <= sdo_next;
      rd_reg <= rd_next;
      last_reg <= last_next;
      stop_reg <= stop_next;
      ack_reg <= ack_next;
      rv_reg <= rv_next;
    end
  end

  // both lines open drain: a one is a release
  assign bus.scl_o = 1'h0;
  assign bus.scl_oe_n = scl_reg;
  assign bus.sda_m_o = 1'h0;
  assign bus.sda_m_oe_n = sdo_reg;
  assign cmd_ready = (st_reg == EEB_MS_IDLE);
  assign rsp_data = rsp_data_reg;
  assign rsp_ack = ack_reg;
  assign rsp_valid = rv_reg;
endmodule

// *** tb/eeb_monitor.sv ***
`timescale 1ns/1ps
module eeb_monitor
  import eeb_pkg::*;
#(
  parameter logic [2:0] DEV_ADDR = EEB_DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // one cycle of slack: start and stop are seen on the raw bus, same sampling for both
  localparam int TBUF_MIN = EEB_TBUF_CYC - 1;
  logic scl_reg, sda_reg, byte0_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [15:0] idle_reg;
  logic start_ev, stop_ev, rise;
  assign start_ev = scl && scl_reg && sda_reg && !sda;
  assign stop_ev = scl && scl_reg && !sda_reg && sda;
  assign rise = scl && !scl_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      byte0_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      idle_reg <= 16'hFFFF;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      if (idle_reg != 16'hFFFF) idle_reg <= idle_reg + 16'h1;
      if (stop_ev) idle_reg <= 16'h0000;
      if (start_ev || stop_ev) begin
        cnt_reg <= 4'h0;
        byte0_reg <= start_ev;
      end else if (rise) begin
        sh_reg <= {sh_reg[6:0], sda};
        cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
        if (cnt_reg == 4'h8) byte0_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    start_ev;
  endsequence
  sequence s_addr_ack;
    rise && byte0_reg && cnt_reg == 4'h8 && !sda_d_oe_n;
  endsequence
  a_dev_edge_low: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("device sda moved while scl high");
  a_dev_bit_hold: assert property ($rose(scl) && !sda_d_oe_n |=> !sda_d_oe_n [*8])
    else $error("device bit not held over scl high");
  a_dev_release: assert property ($fell(sda_d_oe_n) |-> ##[1:1000] $rose(sda_d_oe_n))
    else $error("device kept sda low too long");
  a_start_quiet: assert property (s_start |-> sda_d_oe_n)
    else $error("device drove sda at start");
  a_stop_quiet: assert property (stop_ev |=> sda_d_oe_n [*8])
    else $error("device drove sda after stop");
  a_addr_ninth_only: assert property (rise && byte0_reg && cnt_reg != 4'h8 |-> sda_d_oe_n)
    else $error("device drove sda inside address word");
  a_addr_match: assert property (s_addr_ack |-> sh_reg[7:1] == {EEB_DEV_PREFIX, DEV_ADDR})
    else $error("device acknowledged foreign address");
  a_open_drain: assert property (!sda_d_o && !sda_m_o && !scl_o)
    else $error("line driven high");
  a_reset_idle: assert property ($rose(arst_n) |-> sda_d_oe_n && sda_m_oe_n && scl_oe_n)
    else $error("bus not released after reset");
  a_bus_free: assert property (s_start |-> idle_reg >= TBUF_MIN)
    else $error("start too soon after stop");
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import eeb_pkg::*;
  localparam logic [4:0] C_ST = 5'h10;
  localparam logic [4:0] C_SP = 5'h08;
  localparam logic [4:0] C_RD = 5'h04;
  localparam logic [4:0] C_LA = 5'h02;
  localparam logic [4:0] C_RC = 5'h01;
  logic clk, arst_n;
  logic cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_last, cmd_recover;
  logic [7:0] cmd_byte, tx_data, rx_data, rsp_data;
  logic cmd_ready, rsp_ack, rsp_valid, tx_take, rx_valid, standby, busy;
  int err_count = 0;
  int total_checks = 0;
  int n_rx = 0;
  int n_take = 0;
  int n_rsp = 0;
  int cyc = 0;
  int n;
  eeb_if eeb_if_i();
  // pull-ups on both lines: low only while some party pulls
  assign eeb_if_i.scl = eeb_if_i.scl_oe_n;
  assign eeb_if_i.sda = eeb_if_i.sda_m_oe_n & eeb_if_i.sda_d_oe_n;
  eeb_device #(.TWR_CYC(2000), .DEV_ADDR(3'h5)) eeb_device_i (
    .clk(clk), .arst_n(arst_n), .bus(eeb_if_i), .tx_data(tx_data), .tx_take(tx_take),
    .rx_data(rx_data), .rx_valid(rx_valid), .standby(standby), .busy(busy));
  eeb_master #(.HALF_CYC(16)) eeb_master_i (
    .clk(clk), .arst_n(arst_n), .bus(eeb_if_i), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_last(cmd_last), .cmd_recover(cmd_recover), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
  eeb_monitor #(.DEV_ADDR(3'h5)) eeb_monitor_i (
    .clk(clk), .arst_n(arst_n), .scl_o(eeb_if_i.scl_o), .scl_oe_n(eeb_if_i.scl_oe_n),
    .sda_m_o(eeb_if_i.sda_m_o), .sda_m_oe_n(eeb_if_i.sda_m_oe_n),
    .sda_d_o(eeb_if_i.sda_d_o), .sda_d_oe_n(eeb_if_i.sda_d_oe_n),
    .scl(eeb_if_i.scl), .sda(eeb_if_i.sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // ready is idle, so the request is taken at the first edge and the next byte staged at the following negedge;
  // the device sees the last scl fall some cycles late, so settle before the caller checks
  task automatic cmd(input logic [4:0] f, input logic [7:0] b, input logic [7:0] nxt);
    int k;
    @(negedge clk);
    {cmd_start, cmd_stop, cmd_read, cmd_last, cmd_recover} = f;
    cmd_byte = b;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    tx_data = nxt;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    check("cmd_ready", {7'h0, cmd_ready}, 8'h01);
    repeat (8) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) n_rx++;
    if (tx_take === 1'b1) n_take++;
    if (rsp_valid === 1'b1) n_rsp++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    arst_n = 1'b0;
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_last, cmd_recover} = 6'h00;
    cmd_byte = 8'h00;
    tx_data = 8'h96;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("standby", {7'h0, standby}, 8'h01);
    check("busy", {7'h0, busy}, 8'h00);
    cmd(C_RC, 8'h00, 8'h96);
    check("sda_idle", {7'h0, eeb_if_i.sda}, 8'h01);
    cmd(C_ST, 8'hAA, 8'h96);
    check("wr_addr_ack", {7'h0, rsp_ack}, 8'h01);
    cmd(5'h00, 8'h3C, 8'h96);
    check("ack_d1", {7'h0, rsp_ack}, 8'h01);
    check("rx_d1", rx_data, 8'h3C);
    cmd(C_SP, 8'hA5, 8'h96);
    check("rx_d2", rx_data, 8'hA5);
    check("bus_echo", rsp_data, 8'hA5);
    check("rx_count", n_rx[7:0], 8'h02);
    check("busy_wr", {7'h0, busy}, 8'h01);
    cmd(C_ST | C_SP, 8'hAA, 8'h96);
    check("busy_nack", {7'h0, rsp_ack}, 8'h00);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("standby_wr", {7'h0, standby}, 8'h01);
    cmd(C_ST | C_SP, 8'hA4, 8'h96);
    check("foreign_nack", {7'h0, rsp_ack}, 8'h00);
    check("foreign_standby", {7'h0, standby}, 8'h01);
    cmd(C_ST, 8'hAB, 8'h96);
    check("rd_addr_ack", {7'h0, rsp_ack}, 8'h01);
    cmd(C_RD, 8'h00, 8'h01);
    check("rd_d1", rsp_data, 8'h96);
    cmd(C_RD | C_LA | C_SP, 8'h00, 8'h01);
    check("rd_d2", rsp_data, 8'h01);
    check("rd_nack", {7'h0, rsp_ack}, 8'h00);
    repeat (10) @(negedge clk);
    check("standby_rd", {7'h0, standby}, 8'h01);
    check("busy_rd", {7'h0, busy}, 8'h00);
    check("take_count", n_take[7:0], 8'h02);
    check("rx_after", n_rx[7:0], 8'h02);
    check("rsp_count", n_rsp[7:0], 8'h08);
    summarize();
  end
endmodule
